// ---- bench/mdgc_host.sv ----
// Host model issuing register accesses to the configuration block
`timescale 1ns/1ns
module mdgc_host (
  input  wire logic        sys_clk,
  input  wire logic [31:0] readData,
  input  wire logic        readValid,
  output logic             accessValid,
  output logic      [7:0]  accessAddr,
  output logic      [31:0] accessWriteData
);
  initial {accessValid, accessAddr, accessWriteData} = '0;
  // One access; released lines show the inverse so stale values never match
  task automatic xfer(input logic [7:0] a, input logic [31:0] d, output logic [32:0] q);
    @(posedge sys_clk);
    accessValid <= 1'b1;
    accessAddr <= a;
    accessWriteData <= d;
    @(posedge sys_clk);
    accessValid <= 1'b0;
    accessAddr <= ~a;
    accessWriteData <= ~d;
    @(negedge sys_clk);
    q = {readValid, readData};
  endtask : xfer
endmodule : mdgc_host

// ---- bench/mdgc_properties.sv ----
// Assertions on the global configuration block
`timescale 1ns/1ns
module mdgc_properties import mdgc_pkg::*; #(parameter int SWITCH_CYCLES = 10) (
  input wire logic sys_clk, rst, accessValid, readValid, driverEnable, bridgeACmd1, bridgeBCmd1,
  input wire logic directPwm, extCapFitted, singleMotor, bridgeAOutput1, bridgeBOutput1,
  input wire logic [7:0] accessAddr,
  input wire logic [31:0] accessWriteData, readData
);
  localparam int WAIT = SWITCH_CYCLES + 2;
  // Fast bridge path active, low write bits
  wire logic on = directPwm && driverEnable && extCapFitted;
  wire logic [2:0] low = accessWriteData[2:0];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  reset_clear_a: assert property ($fell(rst) |-> !readData && !directPwm)
    else $error("not clear");
  write_silent_a: assert property (accessValid && accessAddr[7] |=> !readValid)
    else $error("write answered");
  cfg_write_a: assert property (accessValid && accessAddr == MDGC_WRITE_FLAG |=>
    {singleMotor, extCapFitted, directPwm} == $past(low)) else $error("not written");
  reserved_zero_a: assert property (readValid |-> !readData[31:10] && !readData[6:3])
    else $error("reserved set");
  cfg_read_a: assert property (accessValid && !accessAddr |=>
    readData[2:0] == {singleMotor, extCapFitted, directPwm}) else $error("bad read");
  pwm_off_a: assert property ($fell(directPwm) |-> ##[0:WAIT]
    !bridgeAOutput1 && !bridgeBOutput1) else $error("bridge on");
  single_copy_a: assert property (on && singleMotor |=> bridgeBOutput1 == $past(bridgeACmd1))
    else $error("no copy");
  dual_path_a: assert property (on && !singleMotor |=> bridgeBOutput1 == $past(bridgeBCmd1))
    else $error("B not own");
  cover property (accessValid && accessAddr == MDGC_WRITE_FLAG);
  cover property (on && singleMotor);
  cover property ($fell(directPwm));
endmodule : mdgc_properties
bind mdgc_global_config mdgc_properties #(.SWITCH_CYCLES(SWITCH_CYCLES)) i_mdgc_properties (
  .sys_clk, .rst, .accessValid, .readValid, .driverEnable, .bridgeACmd1, .bridgeBCmd1,
  .directPwm, .extCapFitted, .singleMotor, .bridgeAOutput1, .bridgeBOutput1, .accessAddr,
  .accessWriteData, .readData);

// ---- bench/test_motor_driver_global_config.sv ----
// Testbench for the global configuration block
`timescale 1ns/1ns
module test_motor_driver_global_config;
  import mdgc_pkg::*;
  localparam int SW = 1;
  logic sys_clk = 0, rst = 1, driverEnable = 0, accessValid, readValid;
  logic [3:0] cmd = '0, outs; // A1 A2 B1 B2
  logic [7:0] accessAddr;
  logic [31:0] accessWriteData, readData;
  logic [32:0] q;
  int num_errors = 0, cmp_count = 0, n;
  always #5 sys_clk = ~sys_clk;
  mdgc_global_config #(.SWITCH_CYCLES(SW)) i_mdgc_global_config (.sys_clk, .rst, .accessValid,
    .accessAddr, .accessWriteData, .readData, .readValid, .driverEnable, .bridgeACmd1(cmd[3]),
    .bridgeACmd2(cmd[2]), .bridgeBCmd1(cmd[1]), .bridgeBCmd2(cmd[0]), .directPwm(),
    .extCapFitted(), .singleMotor(), .bridgeAOutput1(outs[3]), .bridgeAOutput2(outs[2]),
    .bridgeBOutput1(outs[1]), .bridgeBOutput2(outs[0]));
  mdgc_host i_mdgc_host (.sys_clk, .readData, .readValid, .accessValid, .accessAddr,
    .accessWriteData);
  task automatic chk(input string w, input logic [32:0] e, input logic [32:0] g);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", w, e, g);
    end
  endtask : chk
  task automatic conclude;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude
  // Register write and read; a read answer carries readValid on top
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    i_mdgc_host.xfer(MDGC_WRITE_FLAG | {1'b0, a}, d, q);
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [31:0] e);
    i_mdgc_host.xfer({1'b0, a}, '0, q);
    chk("read", {1'b1, e}, q);
  endtask : rd
  // Cycles until the bridge outputs show the pattern
  task automatic outsAfter(input logic [3:0] e, input int lat);
    n = 0;
    while (outs !== e && n < 40)
    begin
      @(posedge sys_clk);
      #1 n++;
    end
    chk("bridge latency", lat, n);
  endtask : outsAfter
  initial
  begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    rd(7'h00, '0);
    wr(7'h00, 32'hFFFF_FFFF);
    rd(7'h00, 32'h0000_0387);
    wr(7'h01, '0);
    rd(7'h00, 32'h0000_0387);
    rd(7'h01, '0);
    wr(7'h00, 32'h0000_0001);
    @(posedge sys_clk);
    driverEnable <= 1'b1;
    cmd <= 4'h8;
    outsAfter(4'h8, SW + 1);
    wr(7'h00, 32'h0000_0003);
    @(posedge sys_clk);
    cmd <= 4'h3;
    outsAfter(4'h3, 1);
    wr(7'h00, 32'h0000_0007);
    @(posedge sys_clk);
    cmd <= 4'hC;
    outsAfter(4'hF, 1);
    wr(7'h00, 32'h0000_0006);
    outsAfter(4'h0, 1);
    conclude();
  end
  initial
  begin
    #20000;
    num_errors++;
    conclude();
  end
endmodule : test_motor_driver_global_config

// ---- hw/mdgc_global_config.sv ----
// Global configuration register and bridge output steering
//
// Behaviour
// - All registers clear to zero at power-up
// - Address bit 7 set marks a write
// - Registers honour their access class
// - Global configuration at 0x00, 10 bits, RW
// - Bit 0 selects direct PWM operation
// - Bit 1 omits switching delays when set
// - Bit 2 chooses dual or single motor
// - Single motor: bridge A drives both bridges
//
// Notes
// The block sits behind the datagram decoder, which hands over one
// access per accessValid pulse on the same clock.
// Writes carry the write flag in address bit 7; only register 0x00
// is mapped here, writes to any other address are dropped.
// Reads of any other address answer with zero, so the decoder always
// has a reply to frame.
// Bits 7 to 9 are stored but have no function in this block.
// Bits 3 to 6 never hold state, whatever the host writes.
// The bridge outputs are registered. Without the external capacitor
// on the charge pump node the first change of the wanted levels starts
// the switching delay, and the outputs take the levels wanted when it ends.
// While direct PWM is clear all four wanted levels are held low, so an
// early driver enable cannot start a motor.
`timescale 1ns/1ns
module mdgc_global_config
  import mdgc_pkg::*;
#(
  parameter int SWITCH_CYCLES = MDGC_SWITCH_CYCLES
)(
  // Clock and asynchronous reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Register access from the datagram decoder
  input  wire logic        accessValid,
  input  wire logic [7:0]  accessAddr,
  input  wire logic [31:0] accessWriteData,
  // Read answer back to the decoder
  output logic      [31:0] readData,
  output logic             readValid,
  // Driver enable and wanted half-bridge levels
  input  wire logic        driverEnable,
  input  wire logic        bridgeACmd1,
  input  wire logic        bridgeACmd2,
  input  wire logic        bridgeBCmd1,
  input  wire logic        bridgeBCmd2,
  // Configuration fields
  output logic             directPwm,
  output logic             extCapFitted,
  output logic             singleMotor,
  // Bridge drive levels
  output logic             bridgeAOutput1,
  output logic             bridgeAOutput2,
  output logic             bridgeBOutput1,
  output logic             bridgeBOutput2
);

  // Width of the switching delay counter, at least one bit
  localparam int CNT_W = (SWITCH_CYCLES < 2) ? 1 : $clog2(SWITCH_CYCLES + 1);

  //////////////////////////////////////////////////////////////////////////////
  // Address decode helpers

  // True when the access address selects a register write
  function automatic logic mdgc_is_write(input logic [7:0] addr);
    mdgc_is_write = (addr & MDGC_WRITE_FLAG) != 8'h00;
  endfunction : mdgc_is_write

  // True when the low seven address bits select the global configuration
  function automatic logic mdgc_hits_cfg(input logic [7:0] addr);
    mdgc_hits_cfg = addr[MDGC_ADDR_BITS-1:0] == MDGC_ADDR_GLOBAL_CFG;
  endfunction : mdgc_hits_cfg

  //////////////////////////////////////////////////////////////////////////////
  // Register file

  // Stored configuration and the registered read answer
  logic [MDGC_CFG_WIDTH-1:0] globalConfiguration;
  logic [MDGC_CFG_WIDTH-1:0] next_globalConfiguration;
  logic [31:0]               next_readData;
  logic                      next_readValid;
  logic                      writeHit;
  logic                      readReq;

  // Decoded access strobes; an unmapped write matches nothing
  assign writeHit = accessValid && mdgc_is_write(accessAddr) && mdgc_hits_cfg(accessAddr);
  assign readReq  = accessValid && !mdgc_is_write(accessAddr);

  // Next register value and read answer
  always_comb
  begin
    next_globalConfiguration = globalConfiguration;
    next_readData            = readData;
    next_readValid           = 1'b0;
    // Hold by default; readValid is a single-cycle pulse
    if (writeHit)
    begin
      // Reserved bits are dropped so they always read as zero
      next_globalConfiguration = accessWriteData[MDGC_CFG_WIDTH-1:0]
                                 & MDGC_CFG_KEEP_MASK;
    end
    if (readReq)
    begin
      next_readValid = 1'b1;
      if (mdgc_hits_cfg(accessAddr))
      begin
        next_readData = {{(MDGC_DATA_BITS-MDGC_CFG_WIDTH){1'b0}}, globalConfiguration};
      end
      else
      begin
        next_readData = 32'h0000_0000;
      end
    end
  end

  // Register storage, cleared at reset
  // readData keeps the last answer until the next read
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      globalConfiguration <= MDGC_CFG_RESET;
      readData            <= 32'h0000_0000;
      readValid           <= 1'b0;
    end
    else
    begin
      globalConfiguration <= next_globalConfiguration;
      readData            <= next_readData;
      readValid           <= next_readValid;
    end
  end

  // Configuration fields straight from the register
  assign directPwm    = globalConfiguration[MDGC_BIT_DIRECT_PWM];
  assign extCapFitted = globalConfiguration[MDGC_BIT_EXT_CAP];
  assign singleMotor  = globalConfiguration[MDGC_BIT_SINGLE_MOT];

  //////////////////////////////////////////////////////////////////////////////
  // Bridge output steering

  // Bit order of both vectors: 0 A1, 1 A2, 2 B1, 3 B2
  logic [3:0]       wantOut;
  logic [3:0]       bridgeOut;
  logic [3:0]       next_bridgeOut;
  logic [CNT_W-1:0] delayCnt;
  logic [CNT_W-1:0] next_delayCnt;

  // Wanted levels: bridge A copied onto B in single-motor mode, off unless enabled
  always_comb
  begin
    wantOut = 4'h0;
    // Without direct PWM the bridge is held off, so the host must set it first
    if (driverEnable && directPwm)
    begin
      if (singleMotor)
      begin
        // Single motor: bridge B commands are ignored
        wantOut = {bridgeACmd2, bridgeACmd1, bridgeACmd2, bridgeACmd1};
      end
      else
      begin
        // Dual motor: each bridge follows its own commands
        wantOut = {bridgeBCmd2, bridgeBCmd1, bridgeACmd2, bridgeACmd1};
      end
    end
  end

  // Output update, delayed per change unless the capacitor is fitted
  // The delay runs from the first mismatch; a later change of the
  // wanted levels does not restart it, so all four outputs move together
  always_comb
  begin
    next_bridgeOut = bridgeOut;
    next_delayCnt  = delayCnt;
    if (wantOut == bridgeOut)
    begin
      // Nothing pending: restart the delay
      next_delayCnt = '0;
    end
    else if (extCapFitted || delayCnt == CNT_W'(SWITCH_CYCLES))
    begin
      next_bridgeOut = wantOut;
      next_delayCnt  = '0;
    end
    else
    begin
      // Still waiting for the switching delay
      next_delayCnt = delayCnt + CNT_W'(1);
    end
  end

  // Bridge output and delay counter registers
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      bridgeOut <= 4'h0;
      delayCnt  <= '0;
    end
    else
    begin
      bridgeOut <= next_bridgeOut;
      delayCnt  <= next_delayCnt;
    end
  end

  // Drive the pins from the registered levels
  assign bridgeAOutput1 = bridgeOut[0];
  assign bridgeAOutput2 = bridgeOut[1];
  assign bridgeBOutput1 = bridgeOut[2];
  assign bridgeBOutput2 = bridgeOut[3];

endmodule : mdgc_global_config

// ---- hw/mdgc_pkg.sv ----
// Package with register map, field positions and timing for the global configuration block
package mdgc_pkg;
  // Register access
  localparam logic [7:0]  MDGC_WRITE_FLAG      = 8'h80;
  localparam int          MDGC_ADDR_BITS       = 7;
  localparam logic [6:0]  MDGC_ADDR_GLOBAL_CFG = 7'h00;
  localparam int          MDGC_DATA_BITS       = 32;
  localparam int          MDGC_CFG_WIDTH       = 10;
  localparam logic [9:0]  MDGC_CFG_RESET       = 10'h000;
  // Bits that hold state; bits 3 to 6 are reserved and read as zero
  localparam logic [9:0]  MDGC_CFG_KEEP_MASK   = 10'h387;
  // Field positions
  localparam int          MDGC_BIT_DIRECT_PWM  = 0;
  localparam int          MDGC_BIT_EXT_CAP     = 1;
  localparam int          MDGC_BIT_SINGLE_MOT  = 2;
  // Switching delay used without the external charge-pump capacitor
  localparam int          MDGC_CLK_PERIOD_NS   = 10;
  localparam int          MDGC_SWITCH_DELAY_NS = 100;
  localparam int          MDGC_SWITCH_CYCLES   =
    (MDGC_SWITCH_DELAY_NS + MDGC_CLK_PERIOD_NS - 1) / MDGC_CLK_PERIOD_NS;
endpackage : mdgc_pkg
